// File: rtl/pfsw_sequencer.v
// Program flash self-write sequencer top
`timescale 1ns/1ps
`include "pfsw_defines.vh"
module pfsw_sequencer #(
  parameter AW        = 11,
  parameter DW        = 14,
  parameter NSEG      = 8,
  parameter PWRT_CYC  = `PFSW_PWRT_CYC,
  parameter ERASE_CYC = `PFSW_ERASE_CYC
) (
  input  wire            clk_in,
  input  wire            rstn_in,
  input  wire [7:0]      wdata_in,
  input  wire            addr_low_wr_in,
  input  wire            addr_high_wr_in,
  input  wire            data_low_wr_in,
  input  wire            data_high_wr_in,
  input  wire            unlock_key_wr_in,
  input  wire            control_wr_in,
  input  wire [NSEG-1:0] seg_lock_in,
  input  wire [NSEG-1:0] wp_region_in,
  input  wire            code_protect_in,
  input  wire            ext_prog_wr_in,
  input  wire [AW-1:0]   ext_prog_addr_in,
  input  wire [DW-1:0]   ext_prog_data_in,
  output reg  [7:0]      flash_addr_low_out,
  output reg  [AW-9:0]   flash_addr_high_out,
  output reg  [7:0]      flash_data_low_out,
  output reg  [DW-9:0]   flash_data_high_out,
  output reg             write_enable_out,
  output wire            core_stall_out,
  output wire            powerup_busy_out,
  output reg             write_error_out
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_ERASE = 3'h2;
  localparam ST_WAIT  = 3'h3;
  localparam ST_PROG  = 3'h4;
  localparam SW       = $clog2(NSEG);
  localparam RW       = $clog2(`PFSW_REGION_WORDS);
  localparam BW       = $clog2(`PFSW_BLOCK_WORDS);

  reg [2:0]    state_reg;
  reg [22:0]   cnt_reg;
  reg [22:0]   pwrt_reg;
  reg [1:0]    arm_reg;
  reg          rd_pend_reg;
  reg [DW-1:0] buf_reg [0:`PFSW_BLOCK_WORDS-1];
  reg [AW-1:0] base_reg;

  wire [AW-1:0] cur_addr = {flash_addr_high_out, flash_addr_low_out};
  wire [1:0]    cur_idx  = flash_addr_low_out[1:0];
  wire [DW-1:0] cur_data = {flash_data_high_out, flash_data_low_out};
  wire [SW-1:0] cur_seg  = cur_addr[AW-1:AW-SW];
  wire [SW-1:0] ext_seg  = ext_prog_addr_in[AW-1:AW-SW];
  wire          pwrt_run = (pwrt_reg != 23'h0);
  wire          idle     = (state_reg == ST_IDLE);
  wire          start_req = control_wr_in & wdata_in[`PFSW_CTRL_WR_BIT];
  wire          start_ok = start_req & write_enable_out & ~pwrt_run &
                           (arm_reg == `PFSW_ARM_READY) & idle;
  wire          read_req = control_wr_in & wdata_in[`PFSW_CTRL_RD_BIT] &
                           idle & ~start_req;

  // Array write port, sequencer has priority
  reg           arr_we;
  reg [AW-1:0]  arr_wa;
  reg [DW-1:0]  arr_wd;
  wire [DW-1:0] arr_rd;

  always @* begin
    arr_we = 1'b0;
    arr_wa = ext_prog_addr_in;
    arr_wd = ext_prog_data_in;
    if (state_reg == ST_ERASE) begin
      arr_we = 1'b1;
      arr_wa = {base_reg[AW-1:RW], cnt_reg[RW-1:0]};
      arr_wd = `PFSW_ERASED_WORD;
    end else if (state_reg == ST_PROG) begin
      arr_we = 1'b1;
      arr_wa = {base_reg[AW-1:BW], cnt_reg[BW-1:0]};
      arr_wd = buf_reg[cnt_reg[1:0]];
    end else if (idle && ext_prog_wr_in && !pwrt_run) begin
      arr_we = ~wp_region_in[ext_seg] & ~seg_lock_in[ext_seg];
    end
  end

  // Plain words both ways regardless of code protect
  pfsw_array #(
    .AW (AW),
    .DW (DW)
  ) u_array (
    .clk_in      (clk_in),
    .wr_en_in    (arr_we),
    .wr_addr_in  (arr_wa),
    .wr_data_in  (arr_wd),
    .rd_en_in    (read_req),
    .rd_addr_in  (cur_addr),
    .rd_data_out (arr_rd)
  );

  assign core_stall_out   = ~idle;
  assign powerup_busy_out = pwrt_run;

  // Buffer registers, one per word of the block
  genvar gi;
  generate
    for (gi = 0; gi < `PFSW_BLOCK_WORDS; gi = gi + 1) begin : g_buf
      always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          buf_reg[gi] <= `PFSW_ERASED_WORD;
        end else if (start_ok && cur_idx == gi) begin
          buf_reg[gi] <= cur_data;
        end
      end
    end
  endgenerate

  // Unlock key tracking, cleared by any other register write
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      arm_reg <= `PFSW_ARM_NONE;
    end else if (unlock_key_wr_in) begin
      if (wdata_in == `PFSW_KEY_FIRST) begin
        arm_reg <= `PFSW_ARM_FIRST;
      end else if (arm_reg == `PFSW_ARM_FIRST &&
                   wdata_in == `PFSW_KEY_SECOND) begin
        arm_reg <= `PFSW_ARM_READY;
      end else begin
        arm_reg <= `PFSW_ARM_NONE;
      end
    end else if (addr_low_wr_in || addr_high_wr_in || data_low_wr_in ||
                 data_high_wr_in || control_wr_in) begin
      arm_reg <= `PFSW_ARM_NONE;
    end
  end

  // Control registers and commit sequence
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg           <= ST_IDLE;
      cnt_reg             <= 23'h0;
      pwrt_reg            <= PWRT_CYC[22:0];
      rd_pend_reg         <= 1'b0;
      base_reg            <= {AW{1'b0}};
      flash_addr_low_out  <= 8'h00;
      flash_addr_high_out <= {(AW-8){1'b0}};
      flash_data_low_out  <= 8'h00;
      flash_data_high_out <= {(DW-8){1'b0}};
      write_enable_out    <= 1'b0;
      write_error_out     <= 1'b0;
    end else begin
      rd_pend_reg <= read_req;
      if (pwrt_run) begin
        pwrt_reg <= pwrt_reg - 23'h1;
      end
      if (idle) begin
        if (addr_low_wr_in) begin
          flash_addr_low_out <= wdata_in;
        end
        if (addr_high_wr_in) begin
          flash_addr_high_out <= wdata_in[AW-9:0];
        end
        if (data_low_wr_in) begin
          flash_data_low_out <= wdata_in;
        end
        if (data_high_wr_in) begin
          flash_data_high_out <= wdata_in[DW-9:0];
        end
        if (control_wr_in) begin
          write_enable_out <= wdata_in[`PFSW_CTRL_WE_BIT];
        end
      end
      if (rd_pend_reg) begin
        flash_data_low_out  <= arr_rd[7:0];
        flash_data_high_out <= arr_rd[DW-1:8];
      end
      case (state_reg)
        ST_IDLE: begin
          if (start_ok && cur_idx == `PFSW_LAST_IDX) begin
            if (seg_lock_in[cur_seg]) begin
              write_error_out <= 1'b1;
            end else begin
              write_error_out <= 1'b0;
              base_reg  <= {cur_addr[AW-1:BW], {BW{1'b0}}};
              cnt_reg   <= 23'h0;
              state_reg <= ST_SETUP;
            end
          end else if (start_ok) begin
            write_error_out <= 1'b0;
          end
        end
        ST_SETUP: begin
          if (cnt_reg == `PFSW_SETUP_CYC - 1) begin
            cnt_reg   <= 23'h0;
            state_reg <= ST_ERASE;
          end else begin
            cnt_reg <= cnt_reg + 23'h1;
          end
        end
        ST_ERASE: begin
          if (cnt_reg == `PFSW_REGION_WORDS - 1) begin
            cnt_reg   <= 23'h0;
            state_reg <= ST_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 23'h1;
          end
        end
        ST_WAIT: begin
          if (cnt_reg >= ERASE_CYC - 1) begin
            cnt_reg   <= 23'h0;
            state_reg <= ST_PROG;
          end else begin
            cnt_reg <= cnt_reg + 23'h1;
          end
        end
        ST_PROG: begin
          if (cnt_reg == `PFSW_BLOCK_WORDS - 1) begin
            cnt_reg   <= 23'h0;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 23'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // pfsw_sequencer

// File: rtl/pfsw_defines.vh
// Constants for the program flash self-write sequencer
`ifndef PFSW_DEFINES_VH
`define PFSW_DEFINES_VH
`define PFSW_CTRL_RD_BIT   0
`define PFSW_CTRL_WR_BIT   1
`define PFSW_CTRL_WE_BIT   2
`define PFSW_KEY_FIRST     8'h55
`define PFSW_KEY_SECOND    8'hAA
`define PFSW_ERASED_WORD   14'h3FFF
`define PFSW_BLOCK_WORDS   4
`define PFSW_REGION_WORDS  16
`define PFSW_LAST_IDX      2'h3
`define PFSW_SETUP_CYC     2
`define PFSW_CLK_KHZ       125000
`define PFSW_PWRT_MS       64
`define PFSW_ERASE_MS      4
`define PFSW_PWRT_CYC      (`PFSW_PWRT_MS * `PFSW_CLK_KHZ)
`define PFSW_ERASE_CYC     (`PFSW_ERASE_MS * `PFSW_CLK_KHZ)
`define PFSW_ARM_NONE      2'h0
`define PFSW_ARM_FIRST     2'h1
`define PFSW_ARM_READY     2'h2
`endif

// File: rtl/pfsw_array.v
// Program flash word array with registered read data
`timescale 1ns/1ps
module pfsw_array #(
  parameter AW = 11,
  parameter DW = 14
) (
  input  wire          clk_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire          rd_en_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule // pfsw_array

// File: tb/pfsw_sequencer_asserts.sv
// Assertion checker for the flash self-write sequencer
`timescale 1ns/1ps
module pfsw_chk #(
  parameter PWRT_CYC  = 20,
  parameter ERASE_CYC = 8
) (
  input wire       clk_in,
  input wire       rstn_in,
  input wire [7:0] wdata_in,
  input wire       control_wr_in,
  input wire [7:0] seg_lock_in,
  input wire [7:0] flash_addr_low_out,
  input wire [2:0] flash_addr_high_out,
  input wire       write_enable_out,
  input wire       core_stall_out,
  input wire       powerup_busy_out,
  input wire       write_error_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  int stall_cnt_reg;
  int pw_cnt_reg;
  reg start_ok_reg;
  reg lock_hit_reg;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stall_cnt_reg <= 0;
      pw_cnt_reg    <= 0;
    end else begin
      stall_cnt_reg <= core_stall_out ? stall_cnt_reg + 1 : 0;
      pw_cnt_reg    <= pw_cnt_reg + 1;
    end
  end
  always @(posedge clk_in) begin
    lock_hit_reg <= seg_lock_in[flash_addr_high_out];
    start_ok_reg <= control_wr_in & wdata_in[1] & write_enable_out
      & !powerup_busy_out & !core_stall_out
      & (flash_addr_low_out[1:0] == 2'h3);
  end
  stall_len_a: assert property (
    $fell(core_stall_out) |-> stall_cnt_reg == ERASE_CYC + 22)
    else $error("commit stall length wrong");
  stall_cause_a: assert property (
    $rose(core_stall_out) |-> start_ok_reg)
    else $error("stall without valid last-word start");
  pwrt_block_a: assert property (
    powerup_busy_out |-> !core_stall_out)
    else $error("commit during power-up timer");
  pwrt_len_a: assert property (
    $fell(powerup_busy_out) |-> pw_cnt_reg >= PWRT_CYC - 1)
    else $error("power-up timer ended early");
  enable_set_a: assert property (
    $rose(write_enable_out) |-> $past(control_wr_in) && $past(wdata_in[2]))
    else $error("write enable set without control write");
  low_nostall_a: assert property (
    !core_stall_out && control_wr_in && flash_addr_low_out[1:0] != 2'h3
    |=> !core_stall_out) else $error("stall on buffer-only word");
  lock_err_a: assert property (
    $rose(write_error_out) |-> lock_hit_reg && !core_stall_out)
    else $error("error flag without locked segment");
  stall_hold_a: assert property (
    core_stall_out && $past(core_stall_out) |-> $stable(flash_addr_low_out)
    && $stable(write_enable_out)) else $error("registers moved in stall");
endmodule // pfsw_chk

// File: tb/pfsw_cpu_model.sv
// Processor model that drives the flash control registers
`timescale 1ns/1ps
module pfsw_cpu (
  input  wire       clk_in,
  output reg  [7:0] wdata_out,
  output reg  [5:0] strobe_out
);
  initial begin
    wdata_out  = 8'h00;
    strobe_out = 6'h00;
  end
  task wr(input int sel, input [7:0] d);
    @(posedge clk_in);
    #1;
    wdata_out       = d;
    strobe_out[sel] = 1'b1;
    @(posedge clk_in);
    #1;
    strobe_out = 6'h00;
    wdata_out  = ~d;
  endtask
  // Address, data, key, then start
  task word(input [10:0] a, input [13:0] d, input bit key);
    wr(0, a[7:0]);
    wr(1, {5'h00, a[10:8]});
    wr(2, d[7:0]);
    wr(3, {2'h00, d[13:8]});
    if (key) begin
      wr(4, 8'h55);
      wr(4, 8'hAA);
    end
    wr(5, 8'h06);
    repeat (2) @(posedge clk_in);
  endtask
  // Read a word into the data registers, then rebuffer it
  task reload(input [10:0] a);
    wr(0, a[7:0]);
    wr(1, {5'h00, a[10:8]});
    wr(5, 8'h05);
    repeat (2) @(posedge clk_in);
    wr(4, 8'h55);
    wr(4, 8'hAA);
    wr(5, 8'h06);
    repeat (2) @(posedge clk_in);
  endtask
endmodule // pfsw_cpu

// File: tb/pfsw_sequencer_bench.sv
// Self-checking bench for the flash self-write sequencer
`timescale 1ns/1ps
module pfsw_sequencer_bench;
  reg         clk_in, rstn_in, code_protect_in, ext_prog_wr_in;
  reg  [7:0]  seg_lock_in, wp_region_in;
  reg  [10:0] ext_prog_addr_in, base;
  reg  [13:0] ext_prog_data_in;
  wire [7:0]  wdata, addr_lo, data_lo;
  wire [5:0]  strobe, data_hi;
  wire [2:0]  addr_hi;
  wire        we, stall, busy, err;
  int         miscompares, samples_checked, n, stall_n, mem [int];
  bit  [31:0] rng;
  initial begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) stall_n <= stall_n + stall;
  pfsw_cpu i_cpu (.clk_in(clk_in), .wdata_out(wdata), .strobe_out(strobe));
  pfsw_sequencer #(.PWRT_CYC(20), .ERASE_CYC(8)) i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .wdata_in(wdata),
    .addr_low_wr_in(strobe[0]), .addr_high_wr_in(strobe[1]),
    .data_low_wr_in(strobe[2]), .data_high_wr_in(strobe[3]),
    .unlock_key_wr_in(strobe[4]), .control_wr_in(strobe[5]),
    .seg_lock_in(seg_lock_in), .wp_region_in(wp_region_in),
    .code_protect_in(code_protect_in), .ext_prog_wr_in(ext_prog_wr_in),
    .ext_prog_addr_in(ext_prog_addr_in), .ext_prog_data_in(ext_prog_data_in),
    .flash_addr_low_out(addr_lo), .flash_addr_high_out(addr_hi),
    .flash_data_low_out(data_lo), .flash_data_high_out(data_hi),
    .write_enable_out(we), .core_stall_out(stall),
    .powerup_busy_out(busy), .write_error_out(err));
  function bit [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd_chk(input [10:0] a);
    i_cpu.wr(0, a[7:0]);
    i_cpu.wr(1, {5'h00, a[10:8]});
    i_cpu.wr(5, 8'h05);
    repeat (2) @(posedge clk_in);
    #1;
    chk({addr_hi, addr_lo}, a);
    chk({data_hi, data_lo}, mem[a]);
  endtask
  task commit_blk(input bit key, input bit lock);
    bit [13:0] d [4];
    for (int i = 0; i < 4; i++) begin
      d[i] = xs();
      stall_n = 0;
      i_cpu.word(base + i, d[i], key | (i < 3));
      if (i < 3) chk(stall_n, 0);
    end
    for (n = 0; stall !== 1'b0 && n < 200; n++) @(posedge clk_in);
    #1;
    chk(stall_n, (key & !lock) ? 30 : 0);
    chk(err, lock);
    for (int k = 0; k < 16 && key & !lock; k++)
      mem[(base & 11'h7F0) + k] = k / 4 == base[3:2] ? d[k % 4] : 14'h3FFF;
  endtask
  task part_blk(input int idx);
    bit [13:0] v;
    int old [4];
    v = xs();
    for (int i = 0; i < 4; i++) old[i] = mem[base + i];
    old[idx] = v;
    stall_n = 0;
    for (int i = 0; i < 4; i++)
      if (i == idx) i_cpu.word(base + i, v, 1'b1);
      else i_cpu.reload(base + i);
    for (n = 0; stall !== 1'b0 && n < 200; n++) @(posedge clk_in);
    #1;
    chk(stall_n, 30);
    chk(err, 0);
    for (int k = 0; k < 16; k++)
      mem[(base & 11'h7F0) + k] = k / 4 == base[3:2] ? old[k % 4] : 14'h3FFF;
  endtask
  task ext_wr(input [10:0] a, input [13:0] d);
    @(posedge clk_in);
    #1;
    ext_prog_addr_in = a;
    ext_prog_data_in = d;
    ext_prog_wr_in   = 1;
    @(posedge clk_in);
    #1;
    ext_prog_wr_in = 0;
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
  initial begin
    {rstn_in, code_protect_in, ext_prog_wr_in, seg_lock_in} = 0;
    {wp_region_in, ext_prog_addr_in, ext_prog_data_in} = 0;
    {miscompares, samples_checked, stall_n} = 0;
    rng = 32'h9C8B2B70;
    repeat (20) @(posedge clk_in);
    #1 rstn_in = 1;
    chk(we, 0);
    chk(busy, 1);
    stall_n = 0;
    i_cpu.wr(5, 8'h04);
    i_cpu.word(11'h003, 14'h0123, 1'b1);
    chk(stall_n, 0);
    repeat (10) @(posedge clk_in);
    chk(busy, 0);
    for (int r = 0; r < 2; r++) begin
      base = xs() & 11'h7F0;
      code_protect_in = r;
      wp_region_in = r ? 8'hFF : 8'h00;
      commit_blk(1, 0);
      for (int k = 0; k < 16; k++) rd_chk(base + k);
    end
    base = base + 11'h004;
    commit_blk(1, 0);
    part_blk(xs() % 3);
    for (int k = 0; k < 16; k++)
      rd_chk((base & 11'h7F0) + k);
    commit_blk(0, 0);
    seg_lock_in = 8'h01 << base[10:8];
    commit_blk(1, 1);
    seg_lock_in = 0;
    stall_n = 0;
    i_cpu.wr(5, 8'h00);
    i_cpu.word(base + 3, xs(), 1'b1);
    chk(stall_n, 0);
    ext_wr(base, xs());
    wp_region_in = 0;
    ext_wr(base + 1, 14'h1A5C);
    mem[base + 1] = 14'h1A5C;
    for (int k = 0; k < 4; k++) rd_chk(base + k);
    wrap_up;
  end
endmodule // pfsw_sequencer_bench
bind pfsw_sequencer pfsw_chk #(.PWRT_CYC(PWRT_CYC), .ERASE_CYC(ERASE_CYC))
  i_chk (.clk_in(clk_in), .rstn_in(rstn_in), .wdata_in(wdata_in),
  .control_wr_in(control_wr_in), .seg_lock_in(seg_lock_in),
  .flash_addr_low_out(flash_addr_low_out),
  .flash_addr_high_out(flash_addr_high_out),
  .write_enable_out(write_enable_out), .core_stall_out(core_stall_out),
  .powerup_busy_out(powerup_busy_out), .write_error_out(write_error_out));
